// ### logic/imdu_pkg.sv
// shared constants and types for the integer multiply/divide unit
`default_nettype none
package imdu_pkg;
  localparam int WORD_W = 32;
  localparam int DWORD_W = 64;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam int REG_IDX_W = 3;
  localparam int IMM_LSB = 0;
  localparam int OP_W = 3;
  localparam int DIV_STEPS = 64;
  localparam int STEP_W = 7;
  // operation codes on the command port
  localparam logic [2:0] OP_MULTIPLY_MEMORY_WORD = 3'h0;
  localparam logic [2:0] OP_MULTIPLY_REG_REG = 3'h1;
  localparam logic [2:0] OP_MULTIPLY_IMMEDIATE = 3'h2;
  localparam logic [2:0] OP_DIVIDE_MEMORY_BYTE = 3'h3;
  localparam logic [2:0] OP_DIVIDE_MEMORY_HALFWORD = 3'h4;
  localparam logic [2:0] OP_DIVIDE_MEMORY_WORD = 3'h5;
  localparam logic [2:0] OP_DIVIDE_REG_REG = 3'h6;
  localparam logic [2:0] OP_DIVIDE_IMMEDIATE = 3'h7;
  // condition code field order: {exception, positive, negative, zero}
  localparam int CC_W = 4;
  localparam int CC_EXC = 3;
  localparam int CC_POS = 2;
  localparam int CC_NEG = 1;
  localparam int CC_ZERO = 0;
  typedef enum logic [1:0] {IMDU_IDLE, IMDU_DIV, IMDU_DONE} imdu_state_t;
endpackage
`default_nettype wire

// ### logic/imdu_divcore.sv
// unsigned 64 by 32 restoring divider, one quotient bit per cycle
`default_nettype none
module imdu_divcore #(
  parameter int DW = 64,
  parameter int VW = 32,
  parameter int SW = 7
) (
  input wire logic clk, // processor clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic start, // one-cycle start pulse
  input wire logic [DW-1:0] dividend, // magnitude of dividend
  input wire logic [VW-1:0] divisor, // magnitude of divisor, zero passed through and flagged by the caller
  output logic busy, // high while iterating
  output logic done, // one-cycle pulse when result valid
  output logic [DW-1:0] quotient, // full-width quotient magnitude
  output logic [VW-1:0] remainder // remainder magnitude
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [SW-1:0] step;
    logic [DW-1:0] quo;
    logic [VW:0] rem;
    logic [VW-1:0] dvs;
  } imdu_div_t;

  imdu_div_t st_r, st_nxt;
  logic [VW:0] trial;

  // ****************************************
  // shift-subtract iteration
  // ****************************************
  // a full 64-bit quotient is kept so overflow is judged on the exact value
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    trial = '0;
    if (start)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.step = SW'(DW);
      st_nxt.quo = dividend;
      st_nxt.rem = '0;
      st_nxt.dvs = divisor;
    end
    else if (st_r.busy)
    begin
      trial = {st_r.rem[VW-1:0], st_r.quo[DW-1]} - {1'b0, st_r.dvs};
      if (!trial[VW])
      begin
        st_nxt.rem = trial;
        st_nxt.quo = {st_r.quo[DW-2:0], 1'b1};
      end
      else
      begin
        st_nxt.rem = {st_r.rem[VW-1:0], st_r.quo[DW-1]};
        st_nxt.quo = {st_r.quo[DW-2:0], 1'b0};
      end
      st_nxt.step = st_r.step - SW'(1);
      if (st_r.step == SW'(1))
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign busy = st_r.busy;
  assign done = st_r.done;
  assign quotient = st_r.quo;
  assign remainder = st_r.rem[VW-1:0];
endmodule
`default_nettype wire

// ### logic/imdu_top.sv
// integer multiply/divide execution unit with register-pair results
`default_nettype none
module imdu_top (
  input wire logic REF_CLK, // processor clock, 125 MHz
  input wire logic RESET_N, // synchronous reset, active low
  input wire logic START, // one-cycle request pulse, taken when READY
  input wire logic [2:0] OPCODE, // operation select
  input wire logic [2:0] DEST_REG, // pair register number, even
  input wire logic [31:0] EVEN_WORD, // contents of pair even register
  input wire logic [31:0] ODD_WORD, // contents of pair odd register
  input wire logic [31:0] SOURCE_WORD, // source_register_field register contents
  input wire logic [31:0] MEM_WORD, // word at effective_word_address
  input wire logic [15:0] MEM_HALF, // halfword at effective_halfword_address
  input wire logic [7:0] MEM_BYTE, // byte at effective_byte_address
  input wire logic [15:0] IMM_FIELD, // instruction bits 16-31
  output logic READY, // idle and able to take a request
  output logic DONE, // one-cycle pulse, results valid
  output logic WRITE_EN, // one-cycle pulse with DONE, pair write enable
  output logic [2:0] WRITE_EVEN_REG, // even register number to write
  output logic [2:0] WRITE_ODD_REG, // odd register number to write
  output logic [31:0] WRITE_EVEN_DATA, // high word or remainder
  output logic [31:0] WRITE_ODD_DATA, // low word or quotient
  output logic [3:0] PSW_CC, // program_status_word condition bits {exc,pos,neg,zero}
  output logic PSW_CC_WE // one-cycle pulse, update condition bits
);
  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    imdu_pkg::imdu_state_t state;
    logic ready;
    logic done;
    logic wen;
    logic cc_we;
    logic [2:0] reg_even;
    logic [31:0] orig_even;
    logic [31:0] orig_odd;
    logic [31:0] dvs;
    logic [31:0] even_out;
    logic [31:0] odd_out;
    logic [3:0] cc;
  } imdu_top_t;

  imdu_top_t st_r, st_nxt;

  logic div_start;
  logic div_busy;
  logic div_done;
  logic [63:0] div_quo;
  logic [31:0] div_rem;
  logic [63:0] div_dividend;
  logic [31:0] div_divisor;

  // two's complement negation, shared by the magnitude and sign-restore paths
  function automatic logic [63:0] neg64(input logic [63:0] v);
    neg64 = ~v + 64'h0000000000000001;
  endfunction

  function automatic logic [31:0] neg32(input logic [31:0] v);
    neg32 = ~v + 32'h00000001;
  endfunction

  // magnitude of a signed value, returned unsigned at the same width
  function automatic logic [63:0] mag64(input logic [63:0] v);
    mag64 = v[63] ? neg64(v) : v;
  endfunction

  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? neg32(v) : v;
  endfunction

  // sign/zero classification of a signed value into the four condition bits
  function automatic logic [3:0] cc_of(input logic neg, input logic zero);
    logic [3:0] c;
    c = '0;
    c[imdu_pkg::CC_NEG] = neg;
    c[imdu_pkg::CC_ZERO] = zero;
    c[imdu_pkg::CC_POS] = !neg && !zero;
    cc_of = c;
  endfunction

  logic [31:0] mul_a;
  logic [63:0] product;
  logic [31:0] dvs_sel;
  logic is_div;

  // ****************************************
  // operand selection
  // ****************************************
  always_comb
  begin
    is_div = 1'b0;
    mul_a = MEM_WORD;
    dvs_sel = MEM_WORD;
    case (OPCODE)
      imdu_pkg::OP_MULTIPLY_MEMORY_WORD: mul_a = MEM_WORD;
      imdu_pkg::OP_MULTIPLY_REG_REG: mul_a = SOURCE_WORD;
      imdu_pkg::OP_MULTIPLY_IMMEDIATE: mul_a = {{imdu_pkg::HALF_W{IMM_FIELD[15]}}, IMM_FIELD};
      imdu_pkg::OP_DIVIDE_MEMORY_BYTE:
      begin
        is_div = 1'b1;
        dvs_sel = {{(imdu_pkg::WORD_W - imdu_pkg::BYTE_W){1'b0}}, MEM_BYTE};
      end
      imdu_pkg::OP_DIVIDE_MEMORY_HALFWORD:
      begin
        is_div = 1'b1;
        dvs_sel = {{imdu_pkg::HALF_W{MEM_HALF[15]}}, MEM_HALF};
      end
      imdu_pkg::OP_DIVIDE_MEMORY_WORD:
      begin
        is_div = 1'b1;
        dvs_sel = MEM_WORD;
      end
      imdu_pkg::OP_DIVIDE_REG_REG:
      begin
        is_div = 1'b1;
        dvs_sel = SOURCE_WORD;
      end
      default:
      begin
        is_div = 1'b1;
        dvs_sel = {{imdu_pkg::HALF_W{IMM_FIELD[15]}}, IMM_FIELD};
      end
    endcase
  end

  // odd word read from the same port covers the squaring case
  // both factors widened first so the product is formed at full width on every tool
  assign product = $signed({{imdu_pkg::WORD_W{mul_a[31]}}, mul_a}) *
    $signed({{imdu_pkg::WORD_W{ODD_WORD[31]}}, ODD_WORD});

  // divider works on magnitudes, signs are applied afterwards
  assign div_dividend = mag64({st_r.orig_even, st_r.orig_odd});
  assign div_divisor = mag32(st_r.dvs);

  imdu_divcore #(
    .DW(imdu_pkg::DWORD_W),
    .VW(imdu_pkg::WORD_W),
    .SW(imdu_pkg::STEP_W)
  ) u_div (
    .clk(REF_CLK),
    .reset_n(RESET_N),
    .start(div_start),
    .dividend(div_dividend),
    .divisor(div_divisor),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_quo),
    .remainder(div_rem)
  );

  logic d_neg;
  logic q_neg;
  logic [63:0] q_signed;
  logic [31:0] r_signed;
  logic q_ovf;
  logic dvs_zero;

  // ****************************************
  // divide result shaping
  // ****************************************
  // a zero divisor cannot give a 32-bit quotient, so it is an overflow
  always_comb
  begin
    d_neg = st_r.orig_even[31];
    // quotient sign is product of signs
    q_neg = d_neg ^ st_r.dvs[31];
    dvs_zero = (st_r.dvs == '0);
    // a zero magnitude quotient is written as plain zero
    q_signed = q_neg ? neg64(div_quo) : div_quo;
    r_signed = d_neg ? neg32(div_rem) : div_rem;
    // quotient must fit in a signed word
    q_ovf = dvs_zero || (q_signed[63:31] != {33{q_signed[31]}});
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.wen = 1'b0;
    st_nxt.cc_we = 1'b0;
    div_start = 1'b0;
    case (st_r.state)
      imdu_pkg::IMDU_IDLE:
      begin
        st_nxt.ready = 1'b1;
        // a request in the first cycle after reset is not taken: ready is still low
        if (START && st_r.ready)
        begin
          st_nxt.ready = 1'b0;
          // even register names the pair, odd is one higher
          st_nxt.reg_even = {DEST_REG[2:1], 1'b0};
          st_nxt.orig_even = EVEN_WORD;
          st_nxt.orig_odd = ODD_WORD;
          st_nxt.dvs = dvs_sel;
          if (is_div)
            st_nxt.state = imdu_pkg::IMDU_DIV;
          else
          begin
            // high word to even register, low to odd
            st_nxt.even_out = product[63:32];
            st_nxt.odd_out = product[31:0];
            st_nxt.cc = cc_of(product[63], product == '0);
            st_nxt.state = imdu_pkg::IMDU_DONE;
          end
        end
      end
      imdu_pkg::IMDU_DIV:
      begin
        if (!div_busy && !div_done)
          div_start = 1'b1;
        if (div_done)
        begin
          // commit only after the whole result is known
          if (q_ovf)
          begin
            st_nxt.even_out = st_r.orig_even;
            st_nxt.odd_out = st_r.orig_odd;
            st_nxt.cc = '0;
            st_nxt.cc[imdu_pkg::CC_EXC] = 1'b1;
          end
          else
          begin
            st_nxt.even_out = r_signed;
            st_nxt.odd_out = q_signed[31:0];
            // one sign bit from the quotient word
            st_nxt.cc = cc_of(q_signed[31], q_signed[31:0] == '0);
          end
          st_nxt.state = imdu_pkg::IMDU_DONE;
        end
      end
      default:
      begin
        st_nxt.done = 1'b1;
        st_nxt.wen = 1'b1;
        st_nxt.cc_we = 1'b1;
        st_nxt.ready = 1'b1;
        st_nxt.state = imdu_pkg::IMDU_IDLE;
      end
    endcase
  end

  // the divider start is one cycle behind entry so it sees registered operands
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      st_r <= '0;
      st_r.state <= imdu_pkg::IMDU_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // outputs straight from the state record
  // ****************************************
  assign READY = st_r.ready;
  assign DONE = st_r.done;
  assign WRITE_EN = st_r.wen;
  assign WRITE_EVEN_REG = st_r.reg_even;
  assign WRITE_ODD_REG = {st_r.reg_even[2:1], 1'b1};
  assign WRITE_EVEN_DATA = st_r.even_out;
  assign WRITE_ODD_DATA = st_r.odd_out;
  assign PSW_CC = st_r.cc;
  assign PSW_CC_WE = st_r.cc_we;
endmodule
`default_nettype wire

// ### dv/imdu_top_asserts.sv
// concurrent checks on the multiply/divide unit ports
`default_nettype none
module imdu_top_asserts (
  input wire logic REF_CLK, // clock
  input wire logic RESET_N, // sync reset, low
  input wire logic START, // request
  input wire logic [2:0] OPCODE, // operation
  input wire logic READY, // idle
  input wire logic DONE, // result pulse
  input wire logic WRITE_EN, // pair write
  input wire logic [2:0] WRITE_EVEN_REG, // even number
  input wire logic [2:0] WRITE_ODD_REG, // odd number
  input wire logic [31:0] WRITE_EVEN_DATA, // high or remainder
  input wire logic [31:0] WRITE_ODD_DATA, // low or quotient
  input wire logic [3:0] PSW_CC, // condition bits
  input wire logic PSW_CC_WE // condition write
);
  // ****************
  // checks
  // ****************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  logic [2:0] op_r;
  // remember the accepted opcode so the result can be judged by kind
  always_ff @(posedge REF_CLK)
  begin
    if (START && READY)
    begin
      op_r <= OPCODE;
    end
  end
  property p_mul_lat;
    START && READY && OPCODE < imdu_pkg::OP_DIVIDE_MEMORY_BYTE |=> !READY ##1 DONE;
  endproperty
  a_mul_lat: assert property (p_mul_lat) else $error("multiply result late");
  property p_div_lat;
    START && READY && OPCODE >= imdu_pkg::OP_DIVIDE_MEMORY_BYTE |=> !READY [*8] ##[59:61] DONE;
  endproperty
  a_div_lat: assert property (p_div_lat) else $error("divide result late");
  property p_mul_cc;
    DONE && op_r < imdu_pkg::OP_DIVIDE_MEMORY_BYTE |-> PSW_CC == {1'b0,
      $signed({WRITE_EVEN_DATA, WRITE_ODD_DATA}) > 0, WRITE_EVEN_DATA[31], {WRITE_EVEN_DATA, WRITE_ODD_DATA} == 0};
  endproperty
  a_mul_cc: assert property (p_mul_cc) else $error("multiply condition bits wrong");
  property p_div_cc;
    DONE && op_r >= imdu_pkg::OP_DIVIDE_MEMORY_BYTE && !PSW_CC[3] |->
      PSW_CC[2:0] == {$signed(WRITE_ODD_DATA) > 0, WRITE_ODD_DATA[31], WRITE_ODD_DATA == 0};
  endproperty
  a_div_cc: assert property (p_div_cc) else $error("divide condition bits wrong");
  property p_exc;
    DONE && PSW_CC[3] |-> op_r >= imdu_pkg::OP_DIVIDE_MEMORY_BYTE && PSW_CC[2:0] == 3'h0;
  endproperty
  a_exc: assert property (p_exc) else $error("exception bit misused");
  property p_pulses;
    DONE |-> WRITE_EN && PSW_CC_WE && READY;
  endproperty
  a_pulses: assert property (p_pulses) else $error("completion pulses apart");
  property p_wen;
    WRITE_EN |-> DONE;
  endproperty
  a_wen: assert property (p_wen) else $error("pair written early");
  property p_regs;
    DONE |-> !WRITE_EVEN_REG[0] && WRITE_ODD_REG == (WRITE_EVEN_REG | 3'h1);
  endproperty
  a_regs: assert property (p_regs) else $error("pair numbers wrong");
endmodule
bind imdu_top imdu_top_asserts u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .START(START), .OPCODE(OPCODE),
  .READY(READY), .DONE(DONE), .WRITE_EN(WRITE_EN), .WRITE_EVEN_REG(WRITE_EVEN_REG), .WRITE_ODD_REG(WRITE_ODD_REG),
  .WRITE_EVEN_DATA(WRITE_EVEN_DATA), .WRITE_ODD_DATA(WRITE_ODD_DATA), .PSW_CC(PSW_CC), .PSW_CC_WE(PSW_CC_WE));
`default_nettype wire

// ### dv/imdu_regfile.sv
// register file model on the decoder side of the unit
`default_nettype none
module imdu_regfile (
  input wire logic clk, // clock
  input wire logic [2:0] dest, // pair named by decoder
  input wire logic [2:0] src, // source register
  input wire logic we, // pair write
  input wire logic [2:0] wr_even, // even written
  input wire logic [2:0] wr_odd, // odd written
  input wire logic [31:0] wd_even, // even data
  input wire logic [31:0] wd_odd, // odd data
  output logic [31:0] even_word, // pair even
  output logic [31:0] odd_word, // pair odd
  output logic [31:0] src_word // source
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // model
  // ****************
  logic [31:0] rf [8];
  // even pair, odd one higher, any source
  assign even_word = rf[{dest[2:1], 1'b0}];
  assign odd_word = rf[{dest[2:1], 1'b1}];
  assign src_word = rf[src];
  // writeback lands at the edge carrying the pulse, never earlier
  always @(posedge clk)
  begin
    if (we)
    begin
      rf[wr_even] <= wd_even;
      rf[wr_odd] <= wd_odd;
    end
  end
  task automatic load(input logic [2:0] i, input logic [31:0] v);
    rf[i] = v;
  endtask
endmodule
`default_nettype wire

// ### dv/imdu_top_tb.sv
// self-checking bench for the multiply/divide unit
`default_nettype none
module imdu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] op, dst, src; logic [31:0] ev, od, sv, mem, xe, xo; logic [3:0] xc;} imdu_row_t;
  // opcode, pair, source, pair words, source word, operand, expected pair and cc
  imdu_row_t rows [13] = '{
    '{0, 6, 0, 0, 7, 0, 'hFFFFFFFD, 'hFFFFFFFF, 'hFFFFFFEB, 2},
    '{1, 0, 1, 0, 'hE1, 'hE1, 0, 0, 'hC5C1, 4},
    '{5, 0, 2, 1, 0, 0, 2, 1, 0, 8},
    '{3, 6, 0, 5, 6, 0, 'h100, 5, 6, 8},
    '{2, 6, 0, 'h12345678, 'hF37A9B15, 0, 'hAAAA0100, 'hFFFFFFF3, 'h7A9B1500, 2},
    '{3, 0, 2, 0, 'h139, 0, 'hABCDEF04, 1, 'h4E, 4},
    '{3, 2, 0, 0, 'h100, 0, 'h80, 0, 2, 4},
    '{4, 6, 0, 0, 'h3B, 0, 'h1234FFF8, 3, 'hFFFFFFF9, 2},
    '{5, 4, 0, 0, 'h39A20CF, 0, 'hFC000000, 'h39A20CF, 0, 1},
    '{6, 6, 2, 0, 'hF, 'hA, 0, 5, 1, 4},
    '{7, 2, 0, 0, 'h1B7, 0, 'h5555FFFD, 1, 'hFFFFFF6E, 2},
    '{5, 4, 0, 'hFFFFFFFF, 'hFFFFFFF1, 0, 4, 'hFFFFFFFD, 'hFFFFFFFD, 2},
    '{0, 6, 0, 0, 0, 0, 'h80000000, 0, 0, 1}};
  logic ref_clk, reset_n, start, ready, done, write_en, psw_cc_we;
  logic [2:0] op, dst, src, wr_even, wr_odd;
  logic [31:0] mem, even_word, odd_word, src_word, wd_even, wd_odd;
  logic [3:0] psw_cc;
  int num_errors = 0;
  int samples_checked = 0;
  // ****************
  // instances
  // ****************
  imdu_top uut (.REF_CLK(ref_clk), .RESET_N(reset_n), .START(start), .OPCODE(op), .DEST_REG(dst),
    .EVEN_WORD(even_word), .ODD_WORD(odd_word), .SOURCE_WORD(src_word), .MEM_WORD(mem), .MEM_HALF(mem[15:0]),
    .MEM_BYTE(mem[7:0]), .IMM_FIELD(mem[15:0]), .READY(ready), .DONE(done), .WRITE_EN(write_en),
    .WRITE_EVEN_REG(wr_even), .WRITE_ODD_REG(wr_odd), .WRITE_EVEN_DATA(wd_even), .WRITE_ODD_DATA(wd_odd),
    .PSW_CC(psw_cc), .PSW_CC_WE(psw_cc_we));
  imdu_regfile u_rf (.clk(ref_clk), .dest(dst), .src(src), .we(write_en), .wr_even(wr_even), .wr_odd(wr_odd),
    .wd_even(wd_even), .wd_odd(wd_odd), .even_word(even_word), .odd_word(odd_word), .src_word(src_word));
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // one-cycle request pulse, opcode, pair, source and operand held until the next request
  task automatic go(input logic [2:0] o, input logic [2:0] d, input logic [2:0] s, input logic [31:0] m);
    @(negedge ref_clk);
    op = o;
    dst = d;
    src = s;
    mem = m;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
  endtask
  // bounded wait for the completion pulse
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 100)
    begin
      num_errors++;
      $display("mismatch done_pulse exp 1 got %b", done);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // watchdog well past the expected run of under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end
  // ****************
  // sequence
  // ****************
  initial
  begin
    reset_n = 1'b0;
    start = 1'b0;
    op = 3'h0;
    dst = 3'h0;
    src = 3'h0;
    mem = 32'h0;
    repeat (16) @(negedge ref_clk);
    chk4("reset_outputs", 4'h0, {ready, done, write_en, psw_cc_we});
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    foreach (rows[i])
    begin
      u_rf.load(rows[i].src, rows[i].sv);
      u_rf.load({rows[i].dst[2:1], 1'b0}, rows[i].ev);
      u_rf.load({rows[i].dst[2:1], 1'b1}, rows[i].od);
      go(rows[i].op, rows[i].dst, rows[i].src, rows[i].mem);
      wait_done();
      chk4("psw_cc", rows[i].xc, psw_cc);
      @(negedge ref_clk);
      chk32("even_reg", rows[i].xe, u_rf.rf[{rows[i].dst[2:1], 1'b0}]);
      chk32("odd_reg", rows[i].xo, u_rf.rf[{rows[i].dst[2:1], 1'b1}]);
    end
    // a request during a divide is ignored and must not disturb pair 0
    u_rf.load(3'h0, 32'h77);
    u_rf.load(3'h4, 32'h0);
    u_rf.load(3'h5, 32'hF);
    go(3'h5, 3'h4, 3'h0, 32'h3);
    repeat (4) @(negedge ref_clk);
    go(3'h2, 3'h0, 3'h0, 32'h3);
    wait_done();
    chk4("busy_cc", 4'h4, psw_cc);
    @(negedge ref_clk);
    chk32("busy_quot", 32'h5, u_rf.rf[5]);
    chk32("untouched", 32'h77, u_rf.rf[0]);
    // reset in mid-divide: no write may land and the unit must come back idle
    u_rf.load(3'h2, 32'h0);
    u_rf.load(3'h3, 32'h9);
    go(3'h6, 3'h2, 3'h0, 32'h0);
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk4("mid_reset_outputs", 4'h0, {ready, done, write_en, psw_cc_we});
    reset_n = 1'b1;
    repeat (80) @(negedge ref_clk);
    chk32("mid_reset_even", 32'h0, u_rf.rf[2]);
    chk4("idle_after_reset", 4'h8, {ready, done, write_en, psw_cc_we});
    // squaring with the source naming the pair's odd register
    go(3'h1, 3'h2, 3'h3, 32'h0);
    wait_done();
    chk4("square_cc", 4'h4, psw_cc);
    @(negedge ref_clk);
    chk32("square_low", 32'h51, u_rf.rf[3]);
    end_of_test();
  end
endmodule
`default_nettype wire
